// file: rtl/mode_ctrl_pkg.sv
package mode_ctrl_pkg;

  // ----------------------------------------
  // widths and reset values
  // ----------------------------------------
  localparam int          RST_SRC_W        = 8;
  localparam int          SRAM_ARR_W       = 8;
  localparam int          BOOT_STAT_W      = 32;
  localparam int          FILT_W_W         = 5;
  localparam logic [7:0]  RST_IRQ_EN_RST   = 8'h00;
  localparam logic [7:0]  SRAM_MASK_RST    = 8'h00;
  localparam logic [31:0] BOOT_STAT_RST    = 32'h0000_0000;
  localparam logic [4:0]  FILT_WIDTH_RST   = 5'h00;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  // warm reset hold-off, in slow-clock cycles
  localparam int          HOLD_SLOW_CYCLES = 258;
  localparam int          HOLD_CNT_W       = 9;

  // ----------------------------------------
  // low power modes and clock gating modes
  // ----------------------------------------
  typedef enum logic [1:0] {
    LP_ACTIVE_SLEEP,
    LP_DEEP_SLEEP,
    LP_POWER_DOWN,
    LP_DEEP_POWER_DOWN
  } low_power_mode_t;

  typedef enum logic [2:0] {
    CG_NONE,
    CG_CORE,
    CG_CORE_PLATFORM,
    CG_ALL_SYSTEM,
    CG_ALL_SYSTEM_LP
  } clock_gate_mode_t;

  typedef enum logic [1:0] {
    HOLD_IDLE,
    HOLD_WAIT,
    HOLD_FIRE
  } hold_state_t;

endpackage : mode_ctrl_pkg

// file: rtl/pin_filter.sv
`timescale 1ns/10ps
`default_nettype none
module pin_filter
  import mode_ctrl_pkg::*;
#(
  parameter int WIDTH_W = FILT_W_W
) (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               rstSync_n,
  // control
  input  wire logic               enable,
  input  wire logic [WIDTH_W-1:0] width,
  // data
  input  wire logic               pinIn,
  output logic                    pinOut
);

  logic [WIDTH_W-1:0] cnt_r;
  logic               out_r;
  wire                differs = (pinIn != out_r);
  wire                settled = (cnt_r >= width);

  // ----------------------------------------
  // glitch filter: a change must persist width+1 cycles
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      cnt_r <= '0;
      out_r <= 1'b1;
    end else if (!enable || !differs) begin
      cnt_r <= '0;
      out_r <= pinIn;
    end else if (settled) begin
      cnt_r <= '0;
      out_r <= pinIn;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  assign pinOut = out_r;

endmodule : pin_filter
`default_nettype wire

// file: rtl/core_mode_reset_boot_control.sv
// Operation
// - capture isp boot pin at reset pin release; software may read and clear it
// - force bit asserts boot-config pin on next system reset; writing zero does nothing
// - lock blocks writes to boot status and lock; unlock restores; writable shown
// - per-source enable mask gates system reset interrupt sources
// - readable per-source flags; abort needs source removed, then flag cleared
// - software enable gates non-maskable interrupt from dedicated pin
// - all-mode powered-off sram arrays stay unpowered; masters must not access them
// - low-power-only arrays unpowered in low power; others retain contents
// - each sram mask write replaces the previous mask entirely
// - flash wake option wakes flash on any flash access
// - flash doze option disables flash while core sleeps
// - flash disable option puts flash in low power; clearing options does nothing
// - debug-in-sleep control keeps debug alive in sleep; cleared disables it
// - reset pin config holds low-power filter, reset filter enable and width
// - enabled reset interrupt holds off warm reset for 258 slow-clock cycles
// - low-power filter always, reset filter only active; series when both
`timescale 1ns/10ps
`default_nettype none
module core_mode_reset_boot_control
  import mode_ctrl_pkg::*;
#(
  parameter int SRC_W  = RST_SRC_W,
  parameter int ARR_W  = SRAM_ARR_W,
  parameter int HOLD_N = HOLD_SLOW_CYCLES
) (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   reset_n,
  // pins
  input  wire logic                   resetPin_n,
  input  wire logic                   isp_boot_select_pin,
  input  wire logic                   nmiPin,
  input  wire logic                   slow_kilohertz_clock,
  output logic                        bootConfigOut,
  output logic                        nmiOut,
  output logic                        filteredResetPin_n,
  // system reset interrupts
  input  wire logic [SRC_W-1:0]       resetSrcReq,
  input  wire logic [SRC_W-1:0]       rstIrqEnable,
  input  wire logic [SRC_W-1:0]       rstFlagClearWr,
  output logic [SRC_W-1:0]            rstIrqFlags,
  output logic                        rstIrqOut,
  output logic                        warmResetReq,
  // boot capture and force
  output logic                        ispBootLevel,
  input  wire logic                   ispBootClear,
  input  wire logic                   bootForceSet,
  input  wire logic                   systemReset,
  // boot status
  input  wire logic                   bootStatWr,
  input  wire logic [BOOT_STAT_W-1:0] bootStatWrData,
  input  wire logic                   bootLockSet,
  input  wire logic                   bootLockClear,
  output logic [BOOT_STAT_W-1:0]      bootStatus,
  output logic                        bootWritable,
  // nmi, sram, flash, debug
  input  wire logic                   nmiEnable,
  input  wire logic                   sramAllWr,
  input  wire logic                   sramLpWr,
  input  wire logic [ARR_W-1:0]       sramMaskData,
  input  wire logic                   lowPowerActive,
  output logic [ARR_W-1:0]            sramPowerOn,
  input  wire logic                   flashWakeSet,
  input  wire logic                   flashDozeSet,
  input  wire logic                   flashDisableSet,
  input  wire logic                   flashAccess,
  input  wire logic                   coreSleeping,
  output logic                        flashLowPower,
  input  wire logic                   debugInSleep,
  output logic                        debugEnable,
  // reset pin config and low power request
  input  wire logic                   lpFilterEn,
  input  wire logic                   rstFilterEn,
  input  wire logic [FILT_W_W-1:0]    rstFilterWidth,
  input  wire logic                   lpRequest,
  input  wire clock_gate_mode_t       lpClockMode,
  input  wire low_power_mode_t        lpMainMode,
  output clock_gate_mode_t            activeClockMode,
  output low_power_mode_t             activeMainMode
);

  // ----------------------------------------
  // reset release and pin synchronisers
  // ----------------------------------------
  logic [1:0] rstSync_r;
  logic       rstSync_n;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) rstSync_r <= 2'b00;
    else          rstSync_r <= {rstSync_r[0], 1'b1};
  end
  assign rstSync_n = rstSync_r[1];
  logic [3:0] pinMeta_r;
  logic [3:0] pinSync_r;
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      pinMeta_r <= 4'h1;
      pinSync_r <= 4'h1;
    end else begin
      pinMeta_r <= {slow_kilohertz_clock, nmiPin, isp_boot_select_pin, resetPin_n};
      pinSync_r <= pinMeta_r;
    end
  end
  wire rstPinS = pinSync_r[0];
  wire ispPinS = pinSync_r[1];
  wire nmiPinS = pinSync_r[2];
  wire slowS   = pinSync_r[3];

  // ----------------------------------------
  // reset pin filters
  // ----------------------------------------
  logic lpFiltOut;
  logic rstFiltOut;
  wire  rstFiltOn = rstFilterEn && !lowPowerActive;

  pin_filter #(.WIDTH_W(FILT_W_W)) u_lp_filter (
    .clk      (clk),
    .rstSync_n(rstSync_n),
    .enable   (lpFilterEn),
    .width    (rstFilterWidth),
    .pinIn    (rstPinS),
    .pinOut   (lpFiltOut)
  );
  pin_filter #(.WIDTH_W(FILT_W_W)) u_rst_filter (
    .clk      (clk),
    .rstSync_n(rstSync_n),
    .enable   (rstFiltOn),
    .width    (rstFilterWidth),
    .pinIn    (lpFiltOut),
    .pinOut   (rstFiltOut)
  );
  assign filteredResetPin_n = rstFiltOut;

  // ----------------------------------------
  // isp boot capture and boot-config force
  // ----------------------------------------
  logic rstPinPrev_r;
  logic ispLevel_r;
  logic forcePend_r;
  logic bootCfg_r;
  wire  rstRelease = rstFiltOut && !rstPinPrev_r;
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      rstPinPrev_r <= 1'b1; // idle-high level: no false release edge
      ispLevel_r   <= 1'b0;
      forcePend_r  <= 1'b0;
      bootCfg_r    <= 1'b0;
    end else begin
      rstPinPrev_r <= rstFiltOut;
      if (rstRelease)        ispLevel_r <= ispPinS;
      else if (ispBootClear) ispLevel_r <= 1'b0;
      if (bootForceSet)      forcePend_r <= 1'b1;
      if (systemReset) begin
        bootCfg_r <= forcePend_r;
        forcePend_r <= bootForceSet;
      end
    end
  end
  assign ispBootLevel  = ispLevel_r;
  assign bootConfigOut = bootCfg_r;

  // ----------------------------------------
  // boot status with lock
  // ----------------------------------------
  logic [BOOT_STAT_W-1:0] bootStat_r;
  logic                   bootLock_r;
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      bootStat_r <= BOOT_STAT_RST;
      bootLock_r <= 1'b0;
    end else if (!bootLock_r) begin
      if (bootStatWr)  bootStat_r <= bootStatWrData;
      if (bootLockSet) bootLock_r <= 1'b1;
    end else if (bootLockClear) begin
      bootLock_r <= 1'b0;
    end
  end
  assign bootStatus   = bootStat_r;
  assign bootWritable = !bootLock_r;

  // ----------------------------------------
  // system reset interrupts and warm reset hold-off
  // ----------------------------------------
  logic [SRC_W-1:0]      flags_r;
  logic [HOLD_CNT_W-1:0] holdCnt_r;
  logic                  slowPrev_r;
  hold_state_t           state_r;
  wire [SRC_W-1:0]       srcEn   = resetSrcReq & rstIrqEnable;
  wire                   anyPend = |flags_r;
  wire                   slowTick = slowS && !slowPrev_r;
  wire                   holdDone = (holdCnt_r == HOLD_CNT_W'(HOLD_N - 1));
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      flags_r    <= '0;
      slowPrev_r <= 1'b0;
      holdCnt_r  <= '0;
      state_r    <= HOLD_IDLE;
    end else begin
      // set wins over write-one-to-clear
      flags_r    <= (flags_r & ~rstFlagClearWr) | srcEn;
      slowPrev_r <= slowS;
      unique case (state_r)
        HOLD_IDLE: begin
          holdCnt_r <= '0;
          if (anyPend) state_r <= HOLD_WAIT;
        end
        HOLD_WAIT: begin
          if (!anyPend) state_r <= HOLD_IDLE;
          else if (slowTick) begin
            if (holdDone) state_r <= HOLD_FIRE;
            else holdCnt_r <= holdCnt_r + 1'b1;
          end
        end
        HOLD_FIRE: begin
          if (!anyPend) state_r <= HOLD_IDLE;
        end
      endcase
    end
  end
  assign rstIrqFlags  = flags_r;
  assign rstIrqOut    = anyPend;
  assign warmResetReq = (state_r == HOLD_FIRE);

  // ----------------------------------------
  // nmi, sram gating, flash, debug
  // ----------------------------------------
  logic [ARR_W-1:0] sramAllOff_r;
  logic [ARR_W-1:0] sramLpOff_r;
  logic             fWake_r;
  logic             fDoze_r;
  logic             fDis_r;
  logic             nmi_r;
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      sramAllOff_r <= SRAM_MASK_RST;
      sramLpOff_r  <= SRAM_MASK_RST;
      fWake_r      <= 1'b0;
      fDoze_r      <= 1'b0;
      fDis_r       <= 1'b0;
      nmi_r        <= 1'b0;
    end else begin
      if (sramAllWr) sramAllOff_r <= sramMaskData;
      if (sramLpWr)  sramLpOff_r  <= sramMaskData;
      if (flashWakeSet)    fWake_r <= 1'b1;
      if (flashDozeSet)    fDoze_r <= 1'b1;
      if (flashDisableSet) fDis_r  <= 1'b1;
      nmi_r <= nmiEnable && nmiPinS;
    end
  end
  assign nmiOut = nmi_r;
  assign sramPowerOn = ~(sramAllOff_r | (lowPowerActive ? sramLpOff_r : '0));
  wire   flashWoken = fWake_r && flashAccess;
  assign flashLowPower = ((fDis_r) || (fDoze_r && coreSleeping)) && !flashWoken;
  assign debugEnable   = !coreSleeping || debugInSleep;

  // ----------------------------------------
  // low power request latch
  // ----------------------------------------
  clock_gate_mode_t cgMode_r;
  low_power_mode_t  lpMode_r;
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      cgMode_r <= CG_NONE;
      lpMode_r <= LP_ACTIVE_SLEEP;
    end else if (lpRequest) begin
      cgMode_r <= lpClockMode;
      lpMode_r <= lpMainMode;
    end
  end
  assign activeClockMode = cgMode_r;
  assign activeMainMode  = lpMode_r;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  chk_flag_clear_one: assert property (@(posedge clk) disable iff (!rstSync_n)
    (rstFlagClearWr[0] && !srcEn[0]) |=> !flags_r[0]) else $error("flag not cleared by write one");
  chk_flag_mask_src: assert property (@(posedge clk) disable iff (!rstSync_n)
    (!flags_r[0] && !srcEn[0]) |=> !flags_r[0]) else $error("masked source raised flag");
  chk_abort_hold: assert property (@(posedge clk) disable iff (!rstSync_n)
    !anyPend |=> !warmResetReq) else $error("warm reset without pending flag");
  chk_lock_blocks: assert property (@(posedge clk) disable iff (!rstSync_n)
    bootLock_r |=> $stable(bootStat_r)) else $error("boot status changed while locked");
  chk_isp_capture: assert property (@(posedge clk) disable iff (!rstSync_n)
    rstRelease |=> (ispLevel_r == $past(ispPinS))) else $error("isp level not captured");
  chk_sram_all_off: assert property (@(posedge clk) disable iff (!rstSync_n)
    (sramAllOff_r & sramPowerOn) == '0) else $error("sram powered while all-mode off");
  chk_sram_replace: assert property (@(posedge clk) disable iff (!rstSync_n)
    sramAllWr |=> (sramAllOff_r == $past(sramMaskData))) else $error("sram mask not replaced");
  chk_flash_doze: assert property (@(posedge clk) disable iff (!rstSync_n)
    (fDoze_r && coreSleeping && !flashAccess) |-> flashLowPower) else $error("flash not dozed in sleep");
  chk_debug_sleep: assert property (@(posedge clk) disable iff (!rstSync_n)
    (coreSleeping && !debugInSleep) |-> !debugEnable) else $error("debug alive in sleep");

endmodule : core_mode_reset_boot_control
`default_nettype wire

// file: verif/pin_side_model.sv
`timescale 1ns/10ps
`default_nettype none
module pin_side_model (
  // commands from the bench
  input  wire logic resetHeld,
  input  wire logic ispLevel,
  input  wire logic nmiLevel,
  // pins toward the block
  output logic      resetPin_n,
  output logic      isp_boot_select_pin,
  output logic      nmiPin,
  output logic      slow_kilohertz_clock
);
  // ----------------------------------------
  // free running slow clock, unrelated phase
  // ----------------------------------------
  initial begin
    slow_kilohertz_clock = 1'b0;
    #7.3;
    forever #15259 slow_kilohertz_clock = ~slow_kilohertz_clock;
  end

  // ----------------------------------------
  // external pins
  // ----------------------------------------
  assign resetPin_n          = ~resetHeld;
  assign isp_boot_select_pin = ispLevel;
  assign nmiPin              = nmiLevel;
endmodule : pin_side_model
`default_nettype wire

// file: verif/core_mode_reset_boot_control_bench.sv
`timescale 1ns/10ps
`default_nettype none
module core_mode_reset_boot_control_bench;
  import mode_ctrl_pkg::*;
  logic clk, reset_n, resetPin_n, isp_boot_select_pin, nmiPin, slow_kilohertz_clock;
  logic bootConfigOut, nmiOut, filteredResetPin_n, rstIrqOut, warmResetReq, ispBootLevel;
  logic ispBootClear, bootForceSet, systemReset, bootStatWr, bootLockSet, bootLockClear;
  logic bootWritable, nmiEnable, sramAllWr, sramLpWr, lowPowerActive, flashWakeSet, flashDozeSet;
  logic flashDisableSet, flashAccess, coreSleeping, flashLowPower, debugInSleep, debugEnable;
  logic lpFilterEn, rstFilterEn, lpRequest, resetHeld, ispLevel, nmiLevel;
  logic [7:0]  resetSrcReq, rstIrqEnable, rstFlagClearWr, rstIrqFlags, sramMaskData, sramPowerOn;
  logic [31:0] bootStatWrData, bootStatus, d;
  logic [4:0]  rstFilterWidth;
  clock_gate_mode_t lpClockMode, activeClockMode;
  low_power_mode_t  lpMainMode, activeMainMode;
  int fail_count = 0;
  int cmp_count  = 0;
  int w;
  int qId[$];
  logic [31:0] qVal[$];

  core_mode_reset_boot_control #(.HOLD_N(4)) dut (.clk, .reset_n, .resetPin_n, .isp_boot_select_pin,
    .nmiPin, .slow_kilohertz_clock, .bootConfigOut, .nmiOut, .filteredResetPin_n, .resetSrcReq,
    .rstIrqEnable, .rstFlagClearWr, .rstIrqFlags, .rstIrqOut, .warmResetReq, .ispBootLevel,
    .ispBootClear, .bootForceSet, .systemReset, .bootStatWr, .bootStatWrData, .bootLockSet,
    .bootLockClear, .bootStatus, .bootWritable, .nmiEnable, .sramAllWr, .sramLpWr, .sramMaskData,
    .lowPowerActive, .sramPowerOn, .flashWakeSet, .flashDozeSet, .flashDisableSet, .flashAccess,
    .coreSleeping, .flashLowPower, .debugInSleep, .debugEnable, .lpFilterEn, .rstFilterEn,
    .rstFilterWidth, .lpRequest, .lpClockMode, .lpMainMode, .activeClockMode, .activeMainMode);

  pin_side_model far (.resetHeld, .ispLevel, .nmiLevel, .resetPin_n, .isp_boot_select_pin, .nmiPin,
    .slow_kilohertz_clock);

  // ----------------------------------------
  // clock and checking helpers
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  function automatic logic [31:0] sel(int i);
    case (i)
      0: return {24'h0, sramPowerOn};
      1: return bootStatus;
      2: return {31'h0, bootWritable};
      3: return {24'h0, rstIrqFlags};
      4: return {31'h0, warmResetReq};
      5: return {31'h0, nmiOut};
      6: return {31'h0, flashLowPower};
      7: return {31'h0, debugEnable};
      8: return {31'h0, ispBootLevel};
      9: return {31'h0, bootConfigOut};
      10: return {30'h0, activeMainMode};
      12: return {31'h0, filteredResetPin_n};
      13: return {31'h0, rstIrqOut};
      default: return {29'h0, activeClockMode};
    endcase
  endfunction : sel

  task automatic check(logic [31:0] seen, logic [31:0] want);
    cmp_count++;
    if (seen !== want) begin
      fail_count++;
      $display("Error at %0t: output seen %h, expected %h", $time, seen, want);
    end
  endtask : check

  // oldest note is compared as soon as one is queued
  initial begin
    forever begin
      wait (qId.size() != 0);
      check(sel(qId[0]), qVal[0]);
      void'(qId.pop_front());
      void'(qVal.pop_front());
    end
  end

  task automatic exp(int i, logic [31:0] v);
    qId.push_back(i);
    qVal.push_back(v);
    #0.1;
  endtask : exp

  task automatic step(int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : step

  task automatic pl(ref logic s);
    s = 1'b1;
    step(1);
    s = 1'b0;
  endtask : pl

  task automatic results();
    $display("comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : results

  initial begin
    #(25ns * 60000);
    fail_count++;
    results();
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    {ispBootClear, bootForceSet, systemReset, bootStatWr, bootLockSet, bootLockClear} = '0;
    {nmiEnable, sramAllWr, sramLpWr, lowPowerActive, flashWakeSet, flashDozeSet} = '0;
    {flashDisableSet, flashAccess, coreSleeping, lpFilterEn, rstFilterEn, lpRequest} = '0;
    {resetHeld, ispLevel, nmiLevel, debugInSleep} = '0;
    {resetSrcReq, rstIrqEnable, rstFlagClearWr, sramMaskData, bootStatWrData} = '0;
    lpClockMode = CG_NONE;
    lpMainMode  = LP_ACTIVE_SLEEP;
    void'($urandom(41));
    rstFilterWidth = 5'($urandom % 4);
    reset_n = 1'b0;
    step(12);
    reset_n = 1'b1;
    step(3);
    exp(0, 32'h0000_00ff);
    exp(2, 32'h1);
    exp(3, 32'h0);
    $display("reset test done");
    d = $urandom;
    bootStatWrData = d;
    pl(bootStatWr);
    exp(1, d);
    pl(bootLockSet);
    exp(2, 32'h0);
    bootStatWrData = ~d;
    pl(bootStatWr);
    exp(1, d);
    pl(bootLockClear);
    exp(2, 32'h1);
    pl(bootStatWr);
    exp(1, ~d);
    $display("boot status test done");
    for (int k = 0; k < 3; k++) begin
      d[7:0] = 8'($urandom);
      sramMaskData = d[7:0];
      pl(sramAllWr);
      exp(0, {24'h0, ~d[7:0]});
    end
    sramMaskData = 8'h00;
    pl(sramAllWr);
    sramMaskData = 8'h3c;
    pl(sramLpWr);
    sramMaskData = 8'h0c;
    pl(sramLpWr);
    exp(0, 32'h0000_00ff);
    lowPowerActive = 1'b1;
    step(1);
    exp(0, 32'h0000_00f3);
    lowPowerActive = 1'b0;
    $display("sram test done");
    resetSrcReq  = 8'h05;
    rstIrqEnable = 8'h03;
    step(2);
    exp(3, 32'h01);
    exp(13, 32'h1);
    exp(4, 32'h0);
    rstFlagClearWr = 8'h03;
    step(1);
    rstFlagClearWr = 8'h00;
    step(1);
    exp(3, 32'h01);
    for (int k = 0; k < 8000 && warmResetReq !== 1'b1; k++)
      step(1);
    exp(4, 32'h1);
    resetSrcReq = 8'h00;
    step(1);
    rstFlagClearWr = 8'h01;
    step(1);
    rstFlagClearWr = 8'h00;
    step(1);
    exp(3, 32'h0);
    exp(13, 32'h0);
    step(1);
    exp(4, 32'h0);
    $display("reset interrupt test done");
    nmiLevel = 1'b1;
    step(4);
    exp(5, 32'h0);
    nmiEnable = 1'b1;
    step(2);
    exp(5, 32'h1);
    $display("nmi test done");
    pl(flashDozeSet);
    coreSleeping = 1'b1;
    step(1);
    exp(6, 32'h1);
    exp(7, 32'h0);
    debugInSleep = 1'b1;
    step(1);
    exp(7, 32'h1);
    coreSleeping = 1'b0;
    step(1);
    exp(6, 32'h0);
    pl(flashWakeSet);
    pl(flashDisableSet);
    exp(6, 32'h1);
    flashAccess = 1'b1;
    step(1);
    exp(6, 32'h0);
    flashAccess = 1'b0;
    step(1);
    exp(6, 32'h1);
    $display("flash and debug test done");
    ispLevel       = 1'b1;
    w              = 2 + $urandom % 4;
    rstFilterWidth = 5'(w);
    lpFilterEn     = 1'b1;
    rstFilterEn    = 1'b1;
    resetHeld      = 1'b1;
    step(w);
    resetHeld = 1'b0;
    // a low pulse of width cycles must not get through
    for (int k = 0; k < 2 * w + 6; k++) begin
      step(1);
      exp(12, 32'h1);
    end
    resetHeld = 1'b1;
    step(3 + 2 * w);
    exp(12, 32'h1);
    step(1);
    exp(12, 32'h0);
    lowPowerActive = 1'b1;
    resetHeld      = 1'b0;
    step(3 + w);
    exp(12, 32'h0);
    step(1);
    exp(12, 32'h1);
    step(2);
    exp(8, 32'h1);
    lowPowerActive = 1'b0;
    pl(ispBootClear);
    exp(8, 32'h0);
    pl(bootForceSet);
    exp(9, 32'h0);
    pl(systemReset);
    exp(9, 32'h1);
    pl(systemReset);
    exp(9, 32'h0);
    $display("boot pin test done");
    for (int m = 0; m < 4; m++) begin
      lpMainMode  = low_power_mode_t'(m);
      lpClockMode = clock_gate_mode_t'(m + 1);
      pl(lpRequest);
      exp(10, 32'(m));
      exp(11, 32'(m + 1));
    end
    $display("low power request test done");
    step(2);
    results();
  end
endmodule : core_mode_reset_boot_control_bench
`default_nettype wire
